/* File: design/rdq_pkg.sv */
// Constants, register map and types for the lane-2 and adaptive-EQ register slice
// How it works
// - Lane-2 emphasis bits 6:4, code 3 reserved
// - Lane-2 swing bits 2:0, reset 3h
// - Lane-2 EQ bits 3:0, 0 min, F max
// - Hysteresis bits 6:4, reset 4h, adds to de-assert
// - De-assert threshold bits 2:0, reset 4h
// - Upper search limit bits 7:4, reset Fh
// - Pattern policy picks read need, pattern 0
// - Start needs detect, optionally update flag cleared
// - Hold-off bit disables outputs during adaptation
// - Mode bit picks where mid-eye hits count
// - Enable bit gates adaptation, else static EQ
// - Sign bit makes over-EQ offset negative
// - Magnitude adds 0..7 or -8..-1, full mode
package rdq_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_LANE2_SWING_EMPH = 8'h18;
   localparam logic [7:0] ADDR_LANE2_EQ         = 8'h19;
   localparam logic [7:0] ADDR_DETECT_TH        = 8'h1A;
   localparam logic [7:0] ADDR_GLOBAL_STATUS    = 8'h1C;
   localparam logic [7:0] ADDR_AEQ_CTRL_A       = 8'h1D;
   localparam logic [7:0] ADDR_AEQ_CTRL_B       = 8'h1E;
   // Reset values
   localparam logic [7:0] RST_LANE2_SWING_EMPH = 8'h03;
   localparam logic [7:0] RST_LANE2_EQ         = 8'h00;
   localparam logic [7:0] RST_DETECT_TH        = 8'h44;
   localparam logic [7:0] RST_AEQ_CTRL_A       = 8'hF3;
   localparam logic [7:0] RST_AEQ_CTRL_B       = 8'h00;
   // Writable bit masks; other bits read zero
   localparam logic [7:0] MASK_SWING_EMPH = 8'h77;
   localparam logic [7:0] MASK_EQ         = 8'h0F;
   localparam logic [7:0] MASK_DETECT_TH  = 8'h77;
   localparam logic [7:0] MASK_AEQ_CTRL_A = 8'hFF;
   localparam logic [7:0] MASK_AEQ_CTRL_B = 8'hFF;
   // Field positions
   localparam int EMPH_LSB     = 4;
   localparam int SWING_LSB    = 0;
   localparam int HYST_LSB     = 4;
   localparam int DEASSERT_LSB = 0;
   localparam int UPPER_LSB    = 4;
   localparam int POLICY_LSB   = 2;
   localparam int START_BIT    = 1;
   localparam int HOLDOFF_BIT  = 0;
   localparam int MODE_BIT     = 7;
   localparam int ENABLE_BIT   = 6;
   localparam int SIGN_BIT     = 3;
   localparam int MAG_LSB      = 0;
   localparam int PD_BIT       = 7;
   localparam int STANDBY_BIT  = 6;
   // Special codes
   localparam logic [2:0] EMPH_RESERVED     = 3'h3;
   localparam logic [2:0] SWING_LINEAR_MAX  = 3'h3;
   localparam logic [3:0] PATTERN_ZERO      = 4'h0;
   localparam logic [3:0] PATTERN_FIRST     = 4'h5;
   localparam logic [3:0] PATTERN_LAST      = 4'h8;
   // Time spent at each equalizer code during the search
   localparam int DWELL_NS     = 160;
   localparam int CLK_NS       = 10;
   localparam int DWELL_CYCLES = (DWELL_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      RDQ_IDLE   = 2'b00,
      RDQ_SEARCH = 2'b01,
      RDQ_DONE   = 2'b10
   } rdq_state_t;
endpackage : rdq_pkg

/* File: design/rdq_regs.sv */
// Lane-2 configuration, signal-detect thresholds and adaptive equalizer controller
`timescale 1ns/1ns
module rdq_regs #(
   parameter int HIT_W = 8
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   input  wire logic       powered_down_flag,
   input  wire logic       standby_flag,
   input  wire logic       linear_mode,
   input  wire logic       signal_present,
   input  wire logic       training_update_flag,
   input  wire logic       rate_change,
   input  wire logic       pattern_reg_read,
   input  wire logic [3:0] training_pattern,
   input  wire logic       mid_eye_hit,
   output logic      [2:0] lane2_emphasis_sel,
   output logic      [2:0] lane2_swing_sel,
   output logic      [3:0] lane2_equalizer_sel,
   output logic      [2:0] detect_hysteresis_sel,
   output logic      [2:0] detect_deassert_level_sel,
   output logic      [3:0] detect_assert_code,
   output logic            hit_count_active,
   output logic            adapt_busy,
   output logic            lane2_output_enable
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0]          swing_emph;
      logic [7:0]          eq;
      logic [7:0]          det_th;
      logic [7:0]          ctrl_a;
      logic [7:0]          ctrl_b;
      rdq_pkg::rdq_state_t state;
      logic [3:0]          code;
      logic [7:0]          dwell;
      logic [HIT_W-1:0]    hits;
      logic [HIT_W-1:0]    best_hits;
      logic [3:0]          best;
      logic [3:0]          adapted;
      logic                pat_read;
      logic [7:0]          rdata;
      logic                rvalid;
   } rdq_st_t;

   localparam rdq_st_t RST = '{
      swing_emph: rdq_pkg::RST_LANE2_SWING_EMPH, eq: rdq_pkg::RST_LANE2_EQ,
      det_th: rdq_pkg::RST_DETECT_TH, ctrl_a: rdq_pkg::RST_AEQ_CTRL_A,
      ctrl_b: rdq_pkg::RST_AEQ_CTRL_B, state: rdq_pkg::RDQ_IDLE,
      code: 4'h0, dwell: 8'h00, hits: '0, best_hits: '0, best: 4'h0,
      adapted: 4'h0, pat_read: 1'b0, rdata: 8'h00, rvalid: 1'b0};

   rdq_st_t st;
   rdq_st_t next_st;

   // Adapted code plus signed over-EQ offset, saturated to 0..15
   function automatic logic [3:0] rdq_apply_offset(input logic [3:0] base, input logic neg,
                                                   input logic [2:0] mag);
      logic signed [5:0] sum;
      // Negative sign reads the magnitude as mag - 8, so codes 0..7 give -8..-1
      sum = $signed({2'b00, base}) + (neg ? $signed({3'b111, mag}) : $signed({3'b000, mag}));
      if (sum < 6'sd0)
         return 4'h0;
      else if (sum > 6'sd15)
         return 4'hF;
      else
         return sum[3:0];
   endfunction : rdq_apply_offset

   ////////////////////////////////////////////////////////////////////////////
   // Field views
   logic [3:0] upper_limit;
   logic [1:0] policy;
   logic       start_cond;
   logic       holdoff;
   logic       hit_mode;
   logic       adaptive_equalizer_enable;
   logic       pattern_ok;
   logic       read_ok;
   logic       start_ok;

   assign upper_limit = st.ctrl_a[rdq_pkg::UPPER_LSB +: 4];
   assign policy      = st.ctrl_a[rdq_pkg::POLICY_LSB +: 2];
   assign start_cond  = st.ctrl_a[rdq_pkg::START_BIT];
   assign holdoff     = st.ctrl_a[rdq_pkg::HOLDOFF_BIT];
   assign hit_mode    = st.ctrl_b[rdq_pkg::MODE_BIT];
   assign adaptive_equalizer_enable      = st.ctrl_b[rdq_pkg::ENABLE_BIT];

   // Pattern 0 admitted only for policies 0 and 2; read needed for 0 and 1
   assign pattern_ok = ((training_pattern >= rdq_pkg::PATTERN_FIRST) &&
                        (training_pattern <= rdq_pkg::PATTERN_LAST)) ||
                       ((training_pattern == rdq_pkg::PATTERN_ZERO) && !policy[0]);
   assign read_ok    = policy[1] || st.pat_read;
   assign start_ok   = adaptive_equalizer_enable && signal_present && pattern_ok && read_ok &&
                       (!start_cond || !training_update_flag);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic: register writes, reads and the search machine
   always_comb begin
      next_st        = st;
      next_st.rvalid = reg_rd;
      // Snooped read arms adaptation; a read in the same cycle as a rate change wins
      if (rate_change)
         next_st.pat_read = 1'b0;
      if (pattern_reg_read)
         next_st.pat_read = 1'b1;
      if (reg_wr) begin
         unique case (reg_addr)
            rdq_pkg::ADDR_LANE2_SWING_EMPH: next_st.swing_emph = reg_wdata & rdq_pkg::MASK_SWING_EMPH;
            rdq_pkg::ADDR_LANE2_EQ:         next_st.eq = reg_wdata & rdq_pkg::MASK_EQ;
            rdq_pkg::ADDR_DETECT_TH:        next_st.det_th = reg_wdata & rdq_pkg::MASK_DETECT_TH;
            rdq_pkg::ADDR_AEQ_CTRL_A:       next_st.ctrl_a = reg_wdata & rdq_pkg::MASK_AEQ_CTRL_A;
            rdq_pkg::ADDR_AEQ_CTRL_B:       next_st.ctrl_b = reg_wdata & rdq_pkg::MASK_AEQ_CTRL_B;
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            rdq_pkg::ADDR_LANE2_SWING_EMPH: next_st.rdata = st.swing_emph;
            rdq_pkg::ADDR_LANE2_EQ:         next_st.rdata = st.eq;
            rdq_pkg::ADDR_DETECT_TH:        next_st.rdata = st.det_th;
            rdq_pkg::ADDR_GLOBAL_STATUS:    next_st.rdata = {powered_down_flag, standby_flag, 6'h00};
            rdq_pkg::ADDR_AEQ_CTRL_A:       next_st.rdata = st.ctrl_a;
            rdq_pkg::ADDR_AEQ_CTRL_B:       next_st.rdata = st.ctrl_b;
            default:                        next_st.rdata = 8'h00;
         endcase
      end
      unique case (st.state)
         rdq_pkg::RDQ_IDLE: begin
            if (start_ok) begin
               next_st.state     = rdq_pkg::RDQ_SEARCH;
               next_st.code      = 4'h0;
               next_st.dwell     = 8'h00;
               next_st.hits      = '0;
               next_st.best      = 4'h0;
               next_st.best_hits = '0;
            end
         end
         rdq_pkg::RDQ_SEARCH: begin
            if (!adaptive_equalizer_enable || !signal_present) begin
               next_st.state = rdq_pkg::RDQ_IDLE;
            end else if (st.dwell == 8'(rdq_pkg::DWELL_CYCLES - 1)) begin
               next_st.dwell = 8'h00;
               next_st.hits  = '0;
               if (st.hits > st.best_hits || st.code == 4'h0) begin
                  next_st.best      = st.code;
                  next_st.best_hits = st.hits;
               end
               if (st.code >= upper_limit) begin
                  next_st.state = rdq_pkg::RDQ_DONE;
               end else begin
                  next_st.code = st.code + 4'h1;
               end
            end else begin
               next_st.dwell = st.dwell + 8'h01;
               if (mid_eye_hit && hit_count_active && st.hits != '1)
                  next_st.hits = st.hits + HIT_W'(1);
            end
         end
         rdq_pkg::RDQ_DONE: begin
            // Over-EQ offset only trims a full-adaptation result
            next_st.adapted = hit_mode ? st.best :
                              rdq_apply_offset(st.best, st.ctrl_b[rdq_pkg::SIGN_BIT],
                                               st.ctrl_b[rdq_pkg::MAG_LSB +: 3]);
            if (!adaptive_equalizer_enable || !signal_present)
               next_st.state = rdq_pkg::RDQ_IDLE;
         end
         default: next_st.state = rdq_pkg::RDQ_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         st <= RST;
      else
         st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs to the analog lane and detector
   logic [2:0] emph_field;
   logic [2:0] swing_field;

   assign emph_field  = st.swing_emph[rdq_pkg::EMPH_LSB +: 3];
   assign swing_field = st.swing_emph[rdq_pkg::SWING_LSB +: 3];

   always_comb begin
      lane2_emphasis_sel = (emph_field == rdq_pkg::EMPH_RESERVED) ? 3'h0 : emph_field;
      lane2_swing_sel    = (linear_mode && swing_field > rdq_pkg::SWING_LINEAR_MAX) ?
                           rdq_pkg::SWING_LINEAR_MAX : swing_field;
      if (adaptive_equalizer_enable && st.state == rdq_pkg::RDQ_DONE && !hit_mode)
         lane2_equalizer_sel = st.adapted;
      else if (adaptive_equalizer_enable && st.state != rdq_pkg::RDQ_IDLE)
         lane2_equalizer_sel = (st.state == rdq_pkg::RDQ_DONE) ? st.adapted : st.code;
      else
         lane2_equalizer_sel = st.eq[3:0];
   end

   assign detect_hysteresis_sel     = st.det_th[rdq_pkg::HYST_LSB +: 3];
   assign detect_deassert_level_sel = st.det_th[rdq_pkg::DEASSERT_LSB +: 3];
   assign detect_assert_code        = {1'b0, detect_hysteresis_sel} + {1'b0, detect_deassert_level_sel};
   assign hit_count_active          = !hit_mode || st.code == 4'h0;
   assign adapt_busy                = st.state == rdq_pkg::RDQ_SEARCH;
   assign lane2_output_enable       = !(holdoff && adapt_busy);
   assign reg_rdata                 = st.rdata;
   assign reg_rvalid                = st.rvalid;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_start_gate: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(adapt_busy) |-> $past(signal_present) && $past(adaptive_equalizer_enable)) else $error("start without detect");
   a_start_update: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(adapt_busy) && $past(start_cond) |-> !$past(training_update_flag))
      else $error("start while update flag set");
   a_holdoff_out: assert property (@(posedge clk) disable iff (!arst_n)
      adapt_busy |-> lane2_output_enable == !holdoff) else $error("hold-off wrong");
   a_emph_resv: assert property (@(posedge clk) disable iff (!arst_n)
      lane2_emphasis_sel != rdq_pkg::EMPH_RESERVED) else $error("reserved emphasis driven");
   a_swing_lin: assert property (@(posedge clk) disable iff (!arst_n)
      linear_mode |-> lane2_swing_sel <= rdq_pkg::SWING_LINEAR_MAX) else $error("reserved swing");
   a_static_eq: assert property (@(posedge clk) disable iff (!arst_n)
      !adaptive_equalizer_enable |-> lane2_equalizer_sel == st.eq[3:0]) else $error("static EQ not used");
   a_upper_lim: assert property (@(posedge clk) disable iff (!arst_n)
      adapt_busy |-> st.code <= upper_limit || st.code == 4'h0) else $error("search past limit");
   a_assert_th: assert property (@(posedge clk) disable iff (!arst_n)
      reg_wr && reg_addr == rdq_pkg::ADDR_DETECT_TH |=>
      detect_assert_code == {1'b0, $past(reg_wdata[6:4])} + {1'b0, $past(reg_wdata[2:0])})
      else $error("assert threshold sum");
   a_resv_zero: assert property (@(posedge clk) disable iff (!arst_n)
      reg_rd && reg_addr == rdq_pkg::ADDR_LANE2_EQ |=> reg_rvalid && reg_rdata[7:4] == 4'h0)
      else $error("reserved bits not zero");
   a_pattern: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(adapt_busy) && !$past(policy[1]) |-> $past(st.pat_read)) else $error("no pattern read");
   a_count_mode: assert property (@(posedge clk) disable iff (!arst_n)
      hit_mode && st.code != 4'h0 |-> !hit_count_active) else $error("hits counted off zero");
   a_offset: assert property (@(posedge clk) disable iff (!arst_n)
      st.state == rdq_pkg::RDQ_DONE && !hit_mode && !st.ctrl_b[3] && st.ctrl_b[2:0] == 3'h0
      |=> st.adapted == $past(st.best) || $past(adaptive_equalizer_enable) == 1'b0) else $error("zero offset moved EQ");
   c_search: cover property (@(posedge clk) disable iff (!arst_n) $rose(adapt_busy));
   c_done: cover property (@(posedge clk) disable iff (!arst_n) $fell(adapt_busy) && st.state == rdq_pkg::RDQ_DONE);
   c_neg_off: cover property (@(posedge clk) disable iff (!arst_n)
      st.state == rdq_pkg::RDQ_DONE && st.ctrl_b[3]);
endmodule : rdq_regs

/* File: test/rdq_regs_bench.sv */
// Self-checking bench for the lane-2 and adaptive equalizer register slice
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module redriver_lane2_signal_present_aeq_regs_bench;
   logic       clk, arst_n, reg_wr, reg_rd, powered_down_flag, standby_flag, linear_mode;
   logic       signal_present, training_update_flag, rate_change, pattern_reg_read, mid_eye_hit;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [3:0] training_pattern, lane2_equalizer_sel, detect_assert_code, eq_s;
   logic [2:0] lane2_emphasis_sel, lane2_swing_sel, detect_hysteresis_sel, detect_deassert_level_sel;
   logic       reg_rvalid, hit_count_active, adapt_busy, lane2_output_enable, hit_en, hca_s, oe_s;
   int         err_count, checked, seed, target, busy_cnt, n;
   int         mdl [0:255];
   logic [7:0] adr [10] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h00, 8'hFF};

   rdq_regs rdq_regs_i (.clk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
      .powered_down_flag, .standby_flag, .linear_mode, .signal_present, .training_update_flag,
      .rate_change, .pattern_reg_read, .training_pattern, .mid_eye_hit, .lane2_emphasis_sel,
      .lane2_swing_sel, .lane2_equalizer_sel, .detect_hysteresis_sel, .detect_deassert_level_sel,
      .detect_assert_code, .hit_count_active, .adapt_busy, .lane2_output_enable);

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, far-side eye monitor and search observer
   always #5 clk = ~clk;

   always @(negedge clk) mid_eye_hit <= hit_en && adapt_busy && lane2_equalizer_sel == 4'(target);

   always @(negedge clk) begin
      if (adapt_busy === 1'b1) begin
         if (busy_cnt == 20) begin // Second code, fifth dwell cycle
            hca_s = hit_count_active;
            eq_s = lane2_equalizer_sel;
            oe_s = lane2_output_enable;
         end
         busy_cnt++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register model
   function automatic int msk(input logic [7:0] a);
      case (a)
         8'h18, 8'h1A: msk = 8'h77;
         8'h19: msk = 8'h0F;
         8'h1D, 8'h1E: msk = 8'hFF;
         default: msk = 0;
      endcase
   endfunction : msk

   function automatic logic [7:0] rexp(input logic [7:0] a);
      rexp = (a == 8'h1C) ? {powered_down_flag, standby_flag, 6'h00} : 8'(mdl[a] & msk(a));
   endfunction : rexp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      mdl[a] = d & msk(a);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      `CHK(reg_rvalid, 1'b1)
      `CHK(reg_rdata, rexp(a))
   endtask : rd

   task automatic chk_fields;
      logic [2:0] e, s, h, d;
      e = 3'(mdl[8'h18] >> 4);
      s = 3'(mdl[8'h18]);
      h = 3'(mdl[8'h1A] >> 4);
      d = 3'(mdl[8'h1A]);
      `CHK(lane2_emphasis_sel, (e == 3'h3) ? 3'h0 : e)
      `CHK(lane2_swing_sel, (linear_mode && s > 3'h3) ? 3'h3 : s)
      `CHK(lane2_equalizer_sel, 4'(mdl[8'h19]))
      `CHK(detect_hysteresis_sel, h)
      `CHK(detect_deassert_level_sel, d)
      `CHK(detect_assert_code, {1'b0, h} + {1'b0, d})
   endtask : chk_fields

   ////////////////////////////////////////////////////////////////////////////////
   // One adaptive search with its start gating and result
   task automatic run(input bit md, sg, input int mg, up, input bit ho, input int po, input bit st);
      int v;
      wr(8'h1E, 8'h00);
      signal_present = 1'b0;
      rate_change = 1'b1;
      @(negedge clk);
      rate_change = 1'b0;
      wr(8'h1D, 8'(up * 16 + po * 4 + st * 2 + ho));
      training_pattern = 4'h0;
      training_update_flag = st;
      target = $unsigned($random(seed)) % (up + 1);
      hit_en = 1'b1;
      busy_cnt = 0;
      wr(8'h1E, 8'(md * 128 + 64 + sg * 8 + mg));
      signal_present = 1'b1;
      repeat (4) @(negedge clk);
      if (st || po[0] || !po[1]) `CHK(adapt_busy, 1'b0)
      training_update_flag = 1'b0;
      training_pattern = 4'h6;
      repeat (4) @(negedge clk);
      if (!po[1]) `CHK(adapt_busy, 1'b0)
      pattern_reg_read = 1'b1;
      @(negedge clk);
      pattern_reg_read = 1'b0;
      // With policy 0 or 1 the read flag lands first, the search starts one edge later
      @(negedge clk);
      n = 0;
      while (adapt_busy !== 1'b0 && n < 300) begin
         @(negedge clk);
         n++;
      end
      `CHK(n < 300, 1'b1)
      `CHK(busy_cnt, (up + 1) * rdq_pkg::DWELL_CYCLES)
      `CHK(oe_s, !ho)
      `CHK(hca_s, !md)
      `CHK(eq_s, 4'h1)
      @(negedge clk);
      v = md ? 0 : target + (sg ? mg - 8 : mg);
      v = (v < 0) ? 0 : (v > 15) ? 15 : v;
      `CHK(lane2_equalizer_sel, 4'(v))
      hit_en = 1'b0;
      signal_present = 1'b0;
      wr(8'h1E, 8'h00);
      `CHK(lane2_equalizer_sel, 4'(mdl[8'h19]))
   endtask : run

   task automatic results;
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog and main sequence
   initial begin
      #800000;
      err_count++;
      results;
   end

   initial begin
      {clk, arst_n, reg_wr, reg_rd, powered_down_flag, standby_flag, linear_mode} = '0;
      {signal_present, training_update_flag, rate_change, pattern_reg_read, hit_en} = '0;
      {reg_addr, reg_wdata, training_pattern, target, busy_cnt, err_count, checked} = '0;
      seed = 95;
      foreach (mdl[i]) mdl[i] = 0;
      mdl[8'h18] = 8'h03;
      mdl[8'h1A] = 8'h44;
      mdl[8'h1D] = 8'hF3;
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      foreach (adr[i]) rd(adr[i]);
      chk_fields;
      `CHK(lane2_output_enable, 1'b1)
      $display("test reset values done");
      for (int i = 0; i < 40; i++) begin
         powered_down_flag = 1'($random(seed));
         standby_flag = 1'($random(seed));
         linear_mode = 1'($random(seed));
         wr(adr[$unsigned($random(seed)) % 10], 8'($random(seed)));
         rd(reg_addr);
         chk_fields;
      end
      $display("test random access done");
      run(1'b0, 1'b0, 2, 3, 1'b1, 2, 1'b1);
      run(1'b1, 1'b0, 3, 2, 1'b0, 3, 1'b0);
      run(1'b0, 1'b1, 5, 4, 1'b1, 1, 1'b0);
      run(1'b0, 1'b1, 0, 1, 1'b0, 0, 1'b1);
      run(1'b0, 1'b0, 7, 15, 1'b1, 2, 1'b0);
      $display("test adaptation done");
      results;
   end
endmodule : redriver_lane2_signal_present_aeq_regs_bench
